/* File: hdl/apb_decode.sv */
`timescale 1ns/1ps
`include "soft_reset_cfg.svh"

// ----------------------------------------------------------------------------
// APB address decoder
// ----------------------------------------------------------------------------
module apb_decode
  import soft_reset_pkg::*;
(
  input wire logic [11:0] paddr,
  output reg_sel_t sel
);

  // Map the byte address to a register selector.
  always_comb
  begin
    unique case (paddr)
      `SRR_OFS_REQ8: sel = SEL_REQ8;
      `SRR_OFS_REQ9: sel = SEL_REQ9;
      `SRR_OFS_REQ10: sel = SEL_REQ10;
      default: sel = SEL_NONE;
    endcase
  end

endmodule : apb_decode

/* File: hdl/masked_req_reg.sv */
`timescale 1ns/1ps
`include "soft_reset_cfg.svh"

// ----------------------------------------------------------------------------
// One request register with upper half-word write mask
// ----------------------------------------------------------------------------
module masked_req_reg
  import soft_reset_pkg::*;
#(
  parameter logic [15:0] RW_BITS = 16'hFFFF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [15:0] q
);

  // Held request bits.
  logic [15:0] q_ff;
  // Bits that this write may change.
  logic [15:0] wr_bits;

  // Mask bit n+16 enables bit n; reserved bits never change.
  assign wr_bits = wdata[31:16] & RW_BITS;

  // Each bit is a flop so per-bit enable is exact.
  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          q_ff[i] <= 1'b0;
        end
        else if (wr_en && wr_bits[i])
        begin
          q_ff[i] <= wdata[i];
        end
        // Otherwise the bit keeps its value
      end
    end
  endgenerate

  assign q = q_ff;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_mask_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && !wdata[31]) |=> (q_ff[15] == $past(q_ff[15])))
    else $error("Unmasked bit 15 changed.");
  a_mask_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && wdata[16] && RW_BITS[0]) |=> (q_ff[0] == $past(wdata[0])))
    else $error("Masked bit 0 not written.");

endmodule : masked_req_reg

/* File: hdl/soft_reset_cfg.svh */
`ifndef SOFT_RESET_CFG_SVH
`define SOFT_RESET_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SRR_OFS_REQ8 12'h320
`define SRR_OFS_REQ9 12'h324
`define SRR_OFS_REQ10 12'h328

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define SRR_MASK_LSB 16
`define SRR_CTRL_W 16
`define SRR_REQ8_RW 16'h00FF
`define SRR_REQ9_RW 16'hFFFF
`define SRR_REQ10_RW 16'h83FF
`define SRR_REQ_RESET 16'h0000
`define SRR_ADDR_W 12

`endif

/* File: hdl/soft_reset_pkg.sv */
// ----------------------------------------------------------------------------
// Types shared by the reset request bank
// ----------------------------------------------------------------------------
package soft_reset_pkg;

  // One decoded APB access.
  typedef struct packed {
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

  // Register selector.
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_REQ8 = 2'b01,
    SEL_REQ9 = 2'b10,
    SEL_REQ10 = 2'b11
  } reg_sel_t;

endpackage : soft_reset_pkg

/* File: hdl/soft_reset_request_bank.sv */
`timescale 1ns/1ps
`include "soft_reset_cfg.svh"

// Notes on behaviour
// - Write bit n only if bit n+16 set
// - Unmasked lower bits keep their value
// - Request bit high holds reset; resets zero
// - Reg9: USB3 PHY APB, microphone resets
// - Reg9: DDR standby and controller resets
// - Reg9: three OTP reset requests
// - Reg9: camera interface APB/AHB/AXI resets
// - Reg9: content protection resets
// - Reg10: DDR PHY divider; 14:10 read zero
// - Reg10: video decoder reset requests
// - Reg10: video codec reset requests
// - Reg8: display processor reset requests
// - Reg8: video subsystem bus resets
// - Reg8 at 0x320 with mask
module soft_reset_request_bank
  import soft_reset_pkg::*;
(
  // Clock and asynchronous active-low reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave port with zero wait states.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register 8 requests.
  output logic display_pixel_reset_request,
  output logic display_ahb_reset_request,
  output logic display_axi_reset_request,
  output logic display_noc_axi_reset_request,
  output logic video_arbiter_reset_request,
  output logic video_bus_bridge_reset_request,
  output logic video_ahb_bus_reset_request,
  output logic video_axi_bus_reset_request,
  // Register 9 requests.
  output logic usb3_phy_pipe_apb_reset_request,
  output logic usb3_phy_otg_apb_reset_request,
  output logic mic_core_reset_request,
  output logic mic_ahb_reset_request,
  output logic ddr_standby_core_reset_request,
  output logic ddr_standby_apb_reset_request,
  output logic ddr_ctrl_axi_reset_request,
  output logic otp_user_reset_request,
  output logic otp_serial_reset_request,
  output logic otp_apb_reset_request,
  output logic camera_apb_reset_request,
  output logic camera_ahb_reset_request,
  output logic camera_axi_reset_request,
  output logic content_prot_ahb_reset_request,
  output logic content_prot_core_reset_request,
  output logic content_prot_axi_reset_request,
  // Register 10 requests.
  output logic ddr_phy_div_reset_request,
  output logic vdec_entropy_reset_request,
  output logic vdec_core_reset_request,
  output logic vdec_noc_ahb_reset_request,
  output logic vdec_ahb_reset_request,
  output logic vdec_noc_axi_reset_request,
  output logic vdec_axi_reset_request,
  output logic vcodec_noc_ahb_reset_request,
  output logic vcodec_ahb_reset_request,
  output logic vcodec_noc_axi_reset_request,
  output logic vcodec_axi_reset_request
);

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------

  // Selected register for the current address.
  reg_sel_t sel;
  // Current bus access, combinational and not registered, kept for clarity of the write path.
  apb_req_t req;
  // Write strobe in the access phase; the slave is zero wait state.
  logic wr_acc;
  // Read strobe in the access phase.
  logic rd_acc;

  // The decoder turns the byte address of the access into a register selector.
  // Anything that does not match a mapped offset comes back as no selection.
  apb_decode u_dec (
    .paddr(req.addr),
    .sel(sel)
  );

  // Gather the bus fields into one carrier so every consumer sees the same view.
  assign req = '{wr: pwrite, addr: paddr, wdata: pwdata};
  // Writes land only in the access phase, so a setup cycle alone never moves a request.
  assign wr_acc = psel && penable && req.wr;
  // A read has no side effect; this strobe only feeds the read checks below.
  assign rd_acc = psel && penable && !req.wr;

  // --------------------------------------------------------------------------
  // Request registers
  // --------------------------------------------------------------------------

  // Lower half-words of the three registers.
  logic [15:0] req8_q;
  logic [15:0] req9_q;
  logic [15:0] req10_q;

  // Each register gets its own write enable from the decoder, so a write to
  // one word can never disturb the requests held in another.

  // Register 8 only has bits 7:0 in this bank.
  masked_req_reg #(.RW_BITS(`SRR_REQ8_RW)) u_req8 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && sel == SEL_REQ8),
    .wdata(req.wdata),
    .q(req8_q)
  );

  // Register 9 has all sixteen bits.
  masked_req_reg #(.RW_BITS(`SRR_REQ9_RW)) u_req9 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && sel == SEL_REQ9),
    .wdata(req.wdata),
    .q(req9_q)
  );

  // Register 10 bits 14:10 are reserved and never written.
  masked_req_reg #(.RW_BITS(`SRR_REQ10_RW)) u_req10 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_acc && sel == SEL_REQ10),
    .wdata(req.wdata),
    .q(req10_q)
  );

  // --------------------------------------------------------------------------
  // Read data and response
  // --------------------------------------------------------------------------

  // Next read word; the mask half always reads zero.
  logic [31:0] nxt_rdata;

  // Select the lower half-word of the addressed register; the mask half and
  // an unmapped address both give zero, so nothing leaks onto the bus.
  always_comb
  begin
    unique case (sel)
      SEL_REQ8: nxt_rdata = {16'h0000, req8_q};
      SEL_REQ9: nxt_rdata = {16'h0000, req9_q};
      SEL_REQ10: nxt_rdata = {16'h0000, req10_q & `SRR_REQ10_RW};
      SEL_NONE: nxt_rdata = 32'h00000000;
    endcase
  end

  // Read data register, loaded in the setup cycle so it is ready at access.
  logic [31:0] prdata_ff;
  // Error flag for unmapped addresses, also prepared in setup.
  logic pslverr_ff;

  // The read word is captured at the end of the setup cycle so that it stands
  // unchanged for the whole access phase; the bus sees zero between transfers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Nothing is being read while the bank is held in reset.
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
    else if (psel && !penable)
    begin
      // Setup cycle: prepare the answer for the access phase that follows.
      prdata_ff <= req.wr ? 32'h00000000 : nxt_rdata;
      pslverr_ff <= (sel == SEL_NONE);
    end
    else if (psel && penable)
    begin
      // Access phase: hold the prepared answer until the master takes it.
      prdata_ff <= prdata_ff;
      pslverr_ff <= pslverr_ff;
    end
    else
    begin
      // Idle bus: drive zero so a stale word never lingers.
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  // Zero wait state: ready is a constant high flop after reset.
  logic pready_ff;

  // Ready is a flop, low through reset and high from the first edge after it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Held low while the bank is in reset.
      pready_ff <= 1'b0;
    end
    else
    begin
      // Every access completes in one cycle.
      pready_ff <= 1'b1;
    end
  end

  assign pready = pready_ff;

  // --------------------------------------------------------------------------
  // Request outputs, driven directly by the register flops
  // --------------------------------------------------------------------------

  // A high bit holds its domain in reset for as long as it stays high.
  // The bits come straight from the register flops, so no glitch reaches a target.
  always_comb
  begin
    // Register 8: display processor pixel, bus and interconnect resets.
    display_pixel_reset_request = req8_q[7];
    display_ahb_reset_request = req8_q[6];
    display_axi_reset_request = req8_q[5];
    display_noc_axi_reset_request = req8_q[4];
    // Register 8: video subsystem bus resets.
    video_arbiter_reset_request = req8_q[3];
    video_bus_bridge_reset_request = req8_q[2];
    video_ahb_bus_reset_request = req8_q[1];
    video_axi_bus_reset_request = req8_q[0];

    // Register 9: USB3 PHY register ports and microphone interface.
    usb3_phy_pipe_apb_reset_request = req9_q[15];
    usb3_phy_otg_apb_reset_request = req9_q[14];
    mic_core_reset_request = req9_q[13];
    mic_ahb_reset_request = req9_q[12];
    // Register 9: DDR standby logic and DDR controller.
    ddr_standby_core_reset_request = req9_q[11];
    ddr_standby_apb_reset_request = req9_q[10];
    ddr_ctrl_axi_reset_request = req9_q[9];
    // Register 9: one-time-programmable memory ports.
    otp_user_reset_request = req9_q[8];
    otp_serial_reset_request = req9_q[7];
    otp_apb_reset_request = req9_q[6];
    // Register 9: camera input interface.
    camera_apb_reset_request = req9_q[5];
    camera_ahb_reset_request = req9_q[4];
    camera_axi_reset_request = req9_q[3];
    // Register 9: content-protection block.
    content_prot_ahb_reset_request = req9_q[2];
    content_prot_core_reset_request = req9_q[1];
    content_prot_axi_reset_request = req9_q[0];

    // Register 10: DDR PHY divider; bits 14 to 10 have no output.
    ddr_phy_div_reset_request = req10_q[15];
    // Register 10: video decoder.
    vdec_entropy_reset_request = req10_q[9];
    vdec_core_reset_request = req10_q[8];
    vdec_noc_ahb_reset_request = req10_q[7];
    vdec_ahb_reset_request = req10_q[6];
    vdec_noc_axi_reset_request = req10_q[5];
    vdec_axi_reset_request = req10_q[4];
    // Register 10: video codec bus and interconnect ports.
    vcodec_noc_ahb_reset_request = req10_q[3];
    vcodec_ahb_reset_request = req10_q[2];
    vcodec_noc_axi_reset_request = req10_q[1];
    vcodec_axi_reset_request = req10_q[0];
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_write_next_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && sel == SEL_REQ9 && pwdata[31]) |=>
      (usb3_phy_pipe_apb_reset_request == $past(pwdata[15])))
    else $error("Register 9 bit 15 not updated next cycle.");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    req10_q[14:10] == 5'h00)
    else $error("Reserved bits of register 10 set.");
  a_mask_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:16] == 16'h0000)
    else $error("Mask half-word read nonzero.");
  a_reg8_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    req8_q[15:8] == 8'h00)
    else $error("Register 8 upper bits changed.");
  a_unmasked_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && sel == SEL_REQ10 && !pwdata[16]) |=>
      $stable(vcodec_axi_reset_request))
    else $error("Unmasked register 10 bit 0 changed.");
  a_read_value: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && sel == SEL_REQ8) |=> (prdata[7:0] == $past(req8_q[7:0])))
    else $error("Register 8 read mismatch.");
  a_other_reg_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && sel == SEL_REQ8) |=> $stable(req9_q))
    else $error("Register 9 changed on register 8 write.");
  a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && sel == SEL_NONE) |=> pslverr)
    else $error("Unmapped access not flagged.");

  // A mapped access never raises the error response.
  a_slverr_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && sel != SEL_NONE) |=> !pslverr)
    else $error("Mapped access flagged as error.");

  // The slave never inserts a wait state.
  a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable) |-> pready)
    else $error("Ready low in access phase.");

  // --------------------------------------------------------------------------
  // Read path checks
  // --------------------------------------------------------------------------
  // Register 8 read returns its display and video bus requests.
  a_read_reg8: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel == SEL_REQ8) |-> (prdata == {16'h0000, req8_q}))
    else $error("Register 8 read data wrong in access.");
  // Register 9 read returns all sixteen request bits.
  a_read_reg9: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel == SEL_REQ9) |-> (prdata == {16'h0000, req9_q}))
    else $error("Register 9 read data wrong in access.");
  // Register 10 read returns its requests with the reserved bits at zero.
  a_read_reg10: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && sel == SEL_REQ10) |-> (prdata == {16'h0000, req10_q}))
    else $error("Register 10 read data wrong in access.");

  // --------------------------------------------------------------------------
  // Write path checks
  // --------------------------------------------------------------------------
  // A masked write to bit 7 of register 8 shows on its output next cycle.
  a_req8_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && sel == SEL_REQ8 && pwdata[23]) |=>
      (display_pixel_reset_request == $past(pwdata[7])))
    else $error("Register 8 bit 7 not updated next cycle.");
  // A masked write to bit 15 of register 10 reaches the divider request.
  a_div_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && sel == SEL_REQ10 && pwdata[31]) |=>
      (ddr_phy_div_reset_request == $past(pwdata[15])))
    else $error("Register 10 bit 15 not updated next cycle.");
  // A write to register 9 leaves register 10 alone.
  a_reg10_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && sel == SEL_REQ9) |=> $stable(req10_q))
    else $error("Register 10 changed on register 9 write.");

endmodule : soft_reset_request_bank

/* File: tb/tb_soft_reset_request_bank.sv */
`timescale 1ns/1ps

// Compares a seen value with an expected one and counts the result.
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end

module tb_soft_reset_request_bank;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  wire [7:0] o8; // Request outputs of register 8.
  wire [15:0] o9; // Request outputs of register 9.
  wire [9:0] o10; // Lower request outputs of register 10.
  wire o10_top; // Divider request of register 10.
  int error_cnt, total_checks, cyc;
  logic [15:0] exp_q [3]; // Expected request values per register.
  logic [11:0] addrs [3] = '{12'h320, 12'h324, 12'h328};
  logic [15:0] rw_bits [3] = '{16'h00FF, 16'hFFFF, 16'h83FF};

  soft_reset_request_bank soft_reset_request_bank_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .display_pixel_reset_request(o8[7]), .display_ahb_reset_request(o8[6]),
    .display_axi_reset_request(o8[5]), .display_noc_axi_reset_request(o8[4]),
    .video_arbiter_reset_request(o8[3]), .video_bus_bridge_reset_request(o8[2]),
    .video_ahb_bus_reset_request(o8[1]), .video_axi_bus_reset_request(o8[0]),
    .usb3_phy_pipe_apb_reset_request(o9[15]), .usb3_phy_otg_apb_reset_request(o9[14]),
    .mic_core_reset_request(o9[13]), .mic_ahb_reset_request(o9[12]),
    .ddr_standby_core_reset_request(o9[11]), .ddr_standby_apb_reset_request(o9[10]),
    .ddr_ctrl_axi_reset_request(o9[9]), .otp_user_reset_request(o9[8]),
    .otp_serial_reset_request(o9[7]), .otp_apb_reset_request(o9[6]),
    .camera_apb_reset_request(o9[5]), .camera_ahb_reset_request(o9[4]),
    .camera_axi_reset_request(o9[3]), .content_prot_ahb_reset_request(o9[2]),
    .content_prot_core_reset_request(o9[1]), .content_prot_axi_reset_request(o9[0]),
    .ddr_phy_div_reset_request(o10_top), .vdec_entropy_reset_request(o10[9]),
    .vdec_core_reset_request(o10[8]), .vdec_noc_ahb_reset_request(o10[7]),
    .vdec_ahb_reset_request(o10[6]), .vdec_noc_axi_reset_request(o10[5]),
    .vdec_axi_reset_request(o10[4]), .vcodec_noc_ahb_reset_request(o10[3]),
    .vcodec_ahb_reset_request(o10[2]), .vcodec_noc_axi_reset_request(o10[1]),
    .vcodec_axi_reset_request(o10[0]));

  // ---------------------------------------------------------------------------
  // Clock and timeout
  // ---------------------------------------------------------------------------
  always #5 pclk = ~pclk;

  // A hang is cut short after far more cycles than the tests need.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Gathers one register's request outputs into its bit layout.
  function automatic logic [15:0] outv(input int i);
    if (i == 0) return {8'h00, o8};
    else if (i == 1) return o9;
    else return {o10_top, 5'h00, o10};
  endfunction : outv

  // One APB transfer; the request is held until pready is seen high.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees ready.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  // Reads register i back and compares every request output with the model.
  task automatic chk_all(input int i);
    logic [31:0] rd;
    logic err;
    xfer(1'b0, addrs[i], 32'h0000_0000, rd, err);
    `CHK("read data", {16'h0000, exp_q[i]}, rd)
    `CHK("read error", 1'b0, err)
    for (int j = 0; j < 3; j++) `CHK("request outputs", exp_q[j], outv(j))
  endtask : chk_all

  // Masked write to register i, then model update and full check.
  task automatic wr_chk(input int i, input logic [15:0] m, input logic [15:0] d);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, addrs[i], {m, d}, rd, err);
    exp_q[i] = ((exp_q[i] & ~m) | (d & m)) & rw_bits[i];
    chk_all(i);
  endtask : wr_chk

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    logic [31:0] rd;
    logic err;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    exp_q = '{16'h0000, 16'h0000, 16'h0000};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) chk_all(i);
    $display("test reset values done");
    // Each bit alone, so a swapped or missing output shows up.
    for (int i = 0; i < 3; i++)
    begin
      for (int n = 0; n < 16; n++)
      begin
        wr_chk(i, 16'h0001 << n, 16'hFFFF);
        wr_chk(i, 16'hFFFF, 16'h0000);
      end
    end
    $display("test bit map done");
    for (int i = 0; i < 3; i++)
    begin
      wr_chk(i, 16'hFFFF, 16'hFFFF);
      wr_chk(i, 16'h0000, 16'h0000);
      wr_chk(i, 16'h5555, 16'h0000);
      wr_chk(i, 16'hAAAA, 16'h5555);
    end
    $display("test write mask done");
    // Load a mixed pattern so the tests below have nonzero requests to keep or clear.
    for (int i = 0; i < 3; i++) wr_chk(i, 16'hFFFF, 16'hA5C3);
    // An unmapped write is refused and leaves all requests alone.
    xfer(1'b1, 12'h32C, 32'hFFFF_FFFF, rd, err);
    `CHK("unmapped write error", 1'b1, err)
    xfer(1'b0, 12'h32C, 32'h0000_0000, rd, err);
    `CHK("unmapped read error", 1'b1, err)
    `CHK("unmapped read data", 32'h0000_0000, rd)
    chk_all(1);
    $display("test unmapped done");
    // A reset in mid-run clears every request at once.
    presetn <= 1'b0;
    #1;
    exp_q = '{16'h0000, 16'h0000, 16'h0000};
    for (int j = 0; j < 3; j++) `CHK("reset outputs", 16'h0000, outv(j))
    `CHK("ready in reset", 1'b0, pready)
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_all(2);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : tb_soft_reset_request_bank
